// ---- pkg/metrology_pkg.sv ----
package metrology_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ         = 200_000_000;
  localparam int unsigned MAIN_RATE_HZ   = 32_000;
  localparam int unsigned AUX_RATE_HZ    = 1_000_000;
  localparam int unsigned MAIN_DIV       = CLK_HZ / MAIN_RATE_HZ;
  localparam int unsigned AUX_DIV        = CLK_HZ / AUX_RATE_HZ;
  localparam int unsigned ZC_HOLDOFF_US  = 1000;
  localparam int unsigned ZC_HOLDOFF     = (ZC_HOLDOFF_US * MAIN_RATE_HZ) / 1_000_000;

  // ----------------------------------------------------------------
  // Window limits
  // ----------------------------------------------------------------
  localparam logic [9:0]  N_MIN          = 10'h004;
  localparam logic [9:0]  N_MAX          = 10'h3FF;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0]  ADDR_CTRL      = 8'h00;
  localparam logic [7:0]  ADDR_OC_THR    = 8'h04;
  localparam logic [7:0]  ADDR_TRIM_I    = 8'h08;
  localparam logic [7:0]  ADDR_TRIM_V    = 8'h0C;
  localparam logic [7:0]  ADDR_INST      = 8'h10;
  localparam logic [7:0]  ADDR_PINST     = 8'h14;
  localparam logic [7:0]  ADDR_RMS       = 8'h18;
  localparam logic [7:0]  ADDR_APPARENT  = 8'h1C;
  localparam logic [7:0]  ADDR_ACTIVE    = 8'h20;
  localparam logic [7:0]  ADDR_REACTIVE  = 8'h24;
  localparam logic [7:0]  ADDR_PF        = 8'h28;
  localparam logic [7:0]  ADDR_STATUS    = 8'h2C;

  // ----------------------------------------------------------------
  // Field positions, reset values and temperature coefficients
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_BYPASS_BIT = 0;
  localparam int unsigned CTRL_N_LSB      = 16;
  localparam logic [15:0] GAIN_RST        = 16'h4000;
  localparam logic [15:0] OFF_RST         = 16'h0000;
  localparam logic [11:0] OC_THR_RST      = 12'h7FF;
  localparam logic [9:0]  FIXED_N_RST     = 10'h200;
  localparam logic [7:0]  TCG_I           = 8'h00;
  localparam logic [7:0]  TCO_I           = 8'h00;
  localparam logic [7:0]  TCG_V           = 8'h00;
  localparam logic [7:0]  TCO_V           = 8'h00;

endpackage

// ---- verilog/power_metrology_engine.sv ----
`timescale 1ns/1ps
// Summary of operation
// (R1) Main current and voltage path sampled at 32 kHz into instantaneous code fields.
// (R2) Instantaneous power equals current code times voltage code each update.
// (R3) Auxiliary 12-bit current path updates at 1 MHz for overcurrent only.
// (R4) Each auxiliary value compared against programmed threshold; exceeding asserts fault.
// (R5) Main current gain and offset trim also applied to auxiliary path.
// (R6) Both channels get gain/offset trim with temperature terms; room trim user-set.
// (R7) Dynamic mode: rising voltage zero crossing closes window and opens next.
// (R8) Sample count and sums grow every sample until next rising crossing; code also closes the window at N_MAX (1023) samples.
// (R9) Results computed on closed window while next window keeps accumulating.
// (R10) Voltage crossing detection uses a time holdoff against noise.
// (R11) RMS current and voltage are sqrt of summed squares divided by N.
// (R12) Apparent power is RMS current times RMS voltage.
// (R13) Active power is summed per-sample products divided by N.
// (R14) Reactive power is sqrt of apparent squared minus active squared.
// (R15) Power factor magnitude is active power over apparent power.
// (R16) One bit reports current leading or lagging, sign of reactive power.
// (R17) That sign comes from relative current and voltage crossing timing.
// (R18) Power factor sign bit with reactive sign identifies load quadrant.
// (R19) Crossing framing default; a control bit selects fixed programmed count.
// (R20) Fixed counts below 4 are replaced by 4.
// (R21) All window results publish together in one cycle.
// (R22) Zero apparent power yields power factor zero, no division.
module power_metrology_engine #(
  parameter int unsigned MAIN_DIV = metrology_pkg::MAIN_DIV
) (
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_ce,
  input  wire logic [15:0] i_adc_i,
  input  wire logic [15:0] i_adc_v,
  input  wire logic [11:0] i_adc_aux,
  input  wire logic [7:0]  i_temp,
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_we,
  input  wire logic        i_re,
  output logic      [31:0] o_rdata,
  output logic             o_overcurrent,
  output logic             o_result_ready
);

  typedef enum logic [3:0] {
    ST_IDLE   = 4'h0,
    ST_DIV_I  = 4'h1,
    ST_SQ_I   = 4'h2,
    ST_DIV_V  = 4'h3,
    ST_SQ_V   = 4'h4,
    ST_DIV_P  = 4'h5,
    ST_MUL    = 4'h6,
    ST_SQ_Q   = 4'h7,
    ST_DIV_PF = 4'h8,
    ST_PUB    = 4'h9
  } eng_state_t;

  // ----------------------------------------------------------------
  // Trim: offset then gain (Q2.14), both with temperature slope
  // ----------------------------------------------------------------
  function automatic logic [15:0] trim(input logic [15:0] raw, input logic [15:0] gain,
                                       input logic [15:0] off, input logic [7:0] temp,
                                       input logic [7:0] tcg, input logic [7:0] tco);
    logic signed [15:0] gt;
    logic signed [15:0] ot;
    logic signed [17:0] g;
    logic signed [17:0] o;
    logic signed [17:0] d;
    logic signed [35:0] p;
    gt = $signed(tcg) * $signed(temp);
    ot = $signed(tco) * $signed(temp);
    g  = $signed({2'b00, gain}) + 18'(gt >>> 4);
    o  = 18'($signed(off)) + 18'(ot >>> 4);
    d  = 18'($signed(raw)) - o;
    p  = (d * g) >>> 14;
    // Saturate rather than wrap so a large trim cannot flip the sign
    if (p > 36'sd32767)
      trim = 16'h7FFF;
    else if (p < -36'sd32768)
      trim = 16'h8000;
    else
      trim = p[15:0];
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic        bypass_n;
  logic [9:0]  fixed_n;
  logic [11:0] oc_thr;
  logic [15:0] gain_i;
  logic [15:0] off_i;
  logic [15:0] gain_v;
  logic [15:0] off_v;

  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      bypass_n <= 1'b0;
      fixed_n  <= metrology_pkg::FIXED_N_RST;
      oc_thr   <= metrology_pkg::OC_THR_RST;
      gain_i   <= metrology_pkg::GAIN_RST;
      off_i    <= metrology_pkg::OFF_RST;
      gain_v   <= metrology_pkg::GAIN_RST;
      off_v    <= metrology_pkg::OFF_RST;
    end
    else if (i_ce && i_we)
    begin
      if (i_addr == metrology_pkg::ADDR_CTRL)
      begin
        bypass_n <= i_wdata[metrology_pkg::CTRL_BYPASS_BIT]; // (R19)
        fixed_n  <= i_wdata[metrology_pkg::CTRL_N_LSB +: 10];
      end
      else if (i_addr == metrology_pkg::ADDR_OC_THR)
        oc_thr <= i_wdata[11:0];
      else if (i_addr == metrology_pkg::ADDR_TRIM_I)
      begin
        gain_i <= i_wdata[15:0]; // (R6)
        off_i  <= i_wdata[31:16];
      end
      else if (i_addr == metrology_pkg::ADDR_TRIM_V)
      begin
        gain_v <= i_wdata[15:0];
        off_v  <= i_wdata[31:16];
      end
    end
  end

  // ----------------------------------------------------------------
  // Sample timebases
  // ----------------------------------------------------------------
  logic [12:0] main_cnt;
  logic [7:0]  aux_cnt;
  logic        main_tick;
  logic        aux_tick;

  assign main_tick = (main_cnt == 13'(MAIN_DIV - 1));
  assign aux_tick  = (aux_cnt == 8'(metrology_pkg::AUX_DIV - 1));

  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      main_cnt <= 13'h0000;
      aux_cnt  <= 8'h00;
    end
    else if (i_ce)
    begin
      main_cnt <= main_tick ? 13'h0000 : main_cnt + 13'h0001; // (R1)
      aux_cnt  <= aux_tick ? 8'h00 : aux_cnt + 8'h01; // (R3)
    end
  end

  // ----------------------------------------------------------------
  // Instantaneous codes and overcurrent
  // ----------------------------------------------------------------
  logic [15:0] icode;
  logic [15:0] vcode;
  logic [31:0] pinst;
  logic        inst_valid;
  logic [15:0] aux_trim;
  logic [11:0] aux_mag;

  assign aux_trim = trim({i_adc_aux, 4'h0}, gain_i, off_i, i_temp,
                         metrology_pkg::TCG_I, metrology_pkg::TCO_I); // (R5)
  assign aux_mag  = aux_trim[15] ? 12'((16'h0000 - aux_trim) >> 4) : aux_trim[15:4];

  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      icode      <= 16'h0000;
      vcode      <= 16'h0000;
      inst_valid <= 1'b0;
    end
    else if (i_ce)
    begin
      inst_valid <= main_tick;
      if (main_tick)
      begin
        icode <= trim(i_adc_i, gain_i, off_i, i_temp,
                      metrology_pkg::TCG_I, metrology_pkg::TCO_I); // (R6)
        vcode <= trim(i_adc_v, gain_v, off_v, i_temp,
                      metrology_pkg::TCG_V, metrology_pkg::TCO_V); // (R1)
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
      pinst <= 32'h0000_0000;
    else if (i_ce && inst_valid)
      pinst <= 32'($signed(icode) * $signed(vcode)); // (R2)
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
      o_overcurrent <= 1'b0;
    else if (i_ce && aux_tick)
      o_overcurrent <= (aux_mag > oc_thr); // (R4)
  end

  // ----------------------------------------------------------------
  // Window framing and accumulation
  // ----------------------------------------------------------------
  logic [9:0]         win_n;
  logic [47:0]        acc_i2;
  logic [47:0]        acc_v2;
  logic signed [47:0] acc_p;
  logic               v_neg;
  logic               i_neg;
  logic [5:0]         v_hold;
  logic [9:0]         izc_pos;
  logic               izc_seen;
  logic [47:0]        cur_i2;
  logic [47:0]        cur_v2;
  logic signed [47:0] cur_p;
  logic               vzc_rise;
  logic               izc_rise;
  logic [9:0]         n_eff;
  logic               close_dyn;
  logic               close_full;
  logic               close_evt;
  logic [47:0]        snap_i2;
  logic [47:0]        snap_v2;
  logic signed [47:0] snap_p;
  logic [9:0]         snap_n;
  logic               snap_lead;

  assign cur_i2   = 48'($signed(icode) * $signed(icode));
  assign cur_v2   = 48'($signed(vcode) * $signed(vcode));
  assign cur_p    = 48'($signed(icode) * $signed(vcode));
  assign vzc_rise = v_neg && !vcode[15] && (v_hold == 6'h00); // (R10)
  assign izc_rise = i_neg && !icode[15];
  assign n_eff    = (fixed_n < metrology_pkg::N_MIN) ? metrology_pkg::N_MIN : fixed_n; // (R20)
  assign close_dyn  = inst_valid && !bypass_n && vzc_rise && (win_n != 10'h000); // (R7)
  assign close_full = inst_valid && !close_dyn &&
                      (bypass_n ? (win_n + 10'h001 >= n_eff)
                                : (win_n + 10'h001 == metrology_pkg::N_MAX)); // (R19)
  assign close_evt  = close_dyn || close_full;

  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      v_neg  <= 1'b0;
      i_neg  <= 1'b0;
      v_hold <= 6'h00;
    end
    else if (i_ce && inst_valid)
    begin
      v_neg <= vcode[15];
      i_neg <= icode[15];
      // Holdoff after a crossing masks ringing around the same edge
      if (vzc_rise)
        v_hold <= 6'(metrology_pkg::ZC_HOLDOFF); // (R10)
      else if (v_hold != 6'h00)
        v_hold <= v_hold - 6'h01;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      win_n    <= 10'h000;
      acc_i2   <= 48'h0000_0000_0000;
      acc_v2   <= 48'h0000_0000_0000;
      acc_p    <= 48'sh0000_0000_0000;
      izc_pos  <= 10'h000;
      izc_seen <= 1'b0;
    end
    else if (i_ce && inst_valid)
    begin
      if (close_dyn)
      begin
        // Crossing sample is the first sample of the new window
        win_n    <= 10'h001; // (R7)
        acc_i2   <= cur_i2;
        acc_v2   <= cur_v2;
        acc_p    <= cur_p;
        izc_seen <= 1'b0;
      end
      else if (close_full)
      begin
        win_n    <= 10'h000;
        acc_i2   <= 48'h0000_0000_0000;
        acc_v2   <= 48'h0000_0000_0000;
        acc_p    <= 48'sh0000_0000_0000;
        izc_seen <= 1'b0;
      end
      else
      begin
        win_n  <= win_n + 10'h001; // (R8)
        acc_i2 <= acc_i2 + cur_i2;
        acc_v2 <= acc_v2 + cur_v2;
        acc_p  <= acc_p + cur_p;
        if (izc_rise && !izc_seen)
        begin
          izc_pos  <= win_n; // (R17)
          izc_seen <= 1'b1;
        end
      end
    end
  end

  // Snapshot frees the accumulators for the next window at once
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      snap_i2   <= 48'h0000_0000_0000;
      snap_v2   <= 48'h0000_0000_0000;
      snap_p    <= 48'sh0000_0000_0000;
      snap_n    <= 10'h000;
      snap_lead <= 1'b0;
    end
    else if (i_ce && close_evt)
    begin
      snap_i2   <= close_dyn ? acc_i2 : acc_i2 + cur_i2; // (R9)
      snap_v2   <= close_dyn ? acc_v2 : acc_v2 + cur_v2;
      snap_p    <= close_dyn ? acc_p : acc_p + cur_p;
      snap_n    <= close_dyn ? win_n : win_n + 10'h001;
      // Current crossing late in the cycle means it leads the voltage
      snap_lead <= izc_seen && ({izc_pos, 1'b0} >= {1'b0, win_n}); // (R17)
    end
  end

  // ----------------------------------------------------------------
  // Result engine: shared serial divider and square root
  // ----------------------------------------------------------------
  eng_state_t  state;
  logic [5:0]  it;
  logic [47:0] dvd;
  logic [31:0] dvs;
  logic [48:0] rem;
  logic [48:0] rem_sh;
  logic [47:0] next_dvd;
  logic [48:0] next_rem;
  logic [63:0] sq_x;
  logic [31:0] root;
  logic [31:0] mask;
  logic [31:0] trial;
  logic [31:0] next_root;
  logic [15:0] sh_irms;
  logic [15:0] sh_vrms;
  logic [31:0] sh_pmag;
  logic [31:0] sh_s;
  logic [31:0] sh_q;
  logic [15:0] sh_pf;
  logic        sh_pos;
  logic [31:0] s_prod;
  logic [47:0] p_abs;

  assign rem_sh    = {rem[47:0], dvd[47]};
  assign next_rem  = (rem_sh >= {17'h00000, dvs}) ? rem_sh - {17'h00000, dvs} : rem_sh;
  assign next_dvd  = {dvd[46:0], (rem_sh >= {17'h00000, dvs})};
  assign trial     = root | mask;
  assign next_root = ((64'(trial) * 64'(trial)) <= sq_x) ? trial : root;
  assign s_prod    = 32'(sh_irms) * 32'(sh_vrms);
  assign p_abs     = snap_p[47] ? 48'h0000_0000_0000 - snap_p : snap_p;

  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      state   <= ST_IDLE;
      it      <= 6'h00;
      dvd     <= 48'h0000_0000_0000;
      dvs     <= 32'h0000_0000;
      rem     <= 49'h0_0000_0000_0000;
      sq_x    <= 64'h0000_0000_0000_0000;
      root    <= 32'h0000_0000;
      mask    <= 32'h0000_0000;
      sh_irms <= 16'h0000;
      sh_vrms <= 16'h0000;
      sh_pmag <= 32'h0000_0000;
      sh_s    <= 32'h0000_0000;
      sh_q    <= 32'h0000_0000;
      sh_pf   <= 16'h0000;
      sh_pos  <= 1'b0;
    end
    else if (i_ce)
    begin
      it   <= it + 6'h01;
      rem  <= next_rem;
      dvd  <= next_dvd;
      root <= next_root;
      mask <= {1'b0, mask[31:1]};
      case (state)
        ST_IDLE:
        begin
          it   <= 6'h00;
          rem  <= 49'h0_0000_0000_0000;
          dvd  <= dvd;
          root <= root;
          if (close_evt)
            state <= ST_DIV_I;
        end
        ST_DIV_I, ST_DIV_V, ST_DIV_P, ST_DIV_PF:
        begin
          if (it == 6'h00)
          begin
            // Load cycle: operands taken from the snapshot, or sh_pmag over sh_s in ST_DIV_PF
            rem <= 49'h0_0000_0000_0000;
            dvs <= (state == ST_DIV_PF) ? sh_s : {22'h000000, snap_n};
            dvd <= (state == ST_DIV_I) ? snap_i2 :
                   (state == ST_DIV_V) ? snap_v2 :
                   (state == ST_DIV_P) ? p_abs : {1'b0, sh_pmag, 15'h0000};
          end
          else if (it == 6'h30)
          begin
            it   <= 6'h00;
            root <= 32'h0000_0000;
            mask <= 32'h8000_0000;
            sq_x <= {16'h0000, next_dvd}; // (R11)
            if (state == ST_DIV_I)
              state <= ST_SQ_I;
            else if (state == ST_DIV_V)
              state <= ST_SQ_V;
            else if (state == ST_DIV_P)
            begin
              sh_pmag <= next_dvd[31:0]; // (R13)
              sh_pos  <= !snap_p[47]; // (R18)
              state   <= ST_MUL;
            end
            else
            begin
              sh_pf <= (next_dvd > 48'h0000_0000_8000) ? 16'h8000 : next_dvd[15:0]; // (R15)
              state <= ST_PUB;
            end
          end
        end
        ST_SQ_I, ST_SQ_V, ST_SQ_Q:
        begin
          if (it == 6'h1F)
          begin
            it <= 6'h00;
            if (state == ST_SQ_I)
            begin
              sh_irms <= next_root[15:0]; // (R11)
              state   <= ST_DIV_V;
            end
            else if (state == ST_SQ_V)
            begin
              sh_vrms <= next_root[15:0];
              state   <= ST_DIV_P;
            end
            else
            begin
              sh_q <= next_root; // (R14)
              if (sh_s == 32'h0000_0000)
              begin
                sh_pf <= 16'h0000; // (R22)
                state <= ST_PUB;
              end
              else
                state <= ST_DIV_PF;
            end
          end
        end
        ST_MUL:
        begin
          it    <= 6'h00;
          root  <= 32'h0000_0000;
          mask  <= 32'h8000_0000;
          sh_s  <= s_prod; // (R12)
          // Rounding can leave P slightly above S; clamp the radicand
          sq_x  <= (sh_pmag >= s_prod) ? 64'h0000_0000_0000_0000 :
                   64'(s_prod) * 64'(s_prod) - 64'(sh_pmag) * 64'(sh_pmag); // (R14)
          state <= ST_SQ_Q;
        end
        ST_PUB:
        begin
          it    <= 6'h00;
          state <= ST_IDLE;
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Published results
  // ----------------------------------------------------------------
  logic [15:0] irms;
  logic [15:0] vrms;
  logic [31:0] apparent;
  logic [31:0] active;
  logic [31:0] reactive;
  logic [15:0] pf;
  logic        posangle;
  logic        pospf;
  logic [9:0]  last_n;

  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      irms           <= 16'h0000;
      vrms           <= 16'h0000;
      apparent       <= 32'h0000_0000;
      active         <= 32'h0000_0000;
      reactive       <= 32'h0000_0000;
      pf             <= 16'h0000;
      posangle       <= 1'b0;
      pospf          <= 1'b0;
      last_n         <= 10'h000;
      o_result_ready <= 1'b0;
    end
    else if (i_ce)
    begin
      o_result_ready <= (state == ST_PUB);
      if (state == ST_PUB)
      begin
        irms     <= sh_irms; // (R21)
        vrms     <= sh_vrms;
        apparent <= sh_s;
        active   <= sh_pos ? sh_pmag : 32'h0000_0000 - sh_pmag; // (R13)
        reactive <= sh_q;
        pf       <= sh_pf;
        posangle <= snap_lead; // (R16)
        pospf    <= sh_pos; // (R18)
        last_n   <= snap_n;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
      o_rdata <= 32'h0000_0000;
    else if (i_ce)
    begin
      o_rdata <= 32'h0000_0000;
      if (i_re)
      begin
        if (i_addr == metrology_pkg::ADDR_CTRL)
          o_rdata <= {6'h00, fixed_n, 15'h0000, bypass_n};
        else if (i_addr == metrology_pkg::ADDR_OC_THR)
          o_rdata <= {20'h00000, oc_thr};
        else if (i_addr == metrology_pkg::ADDR_TRIM_I)
          o_rdata <= {off_i, gain_i};
        else if (i_addr == metrology_pkg::ADDR_TRIM_V)
          o_rdata <= {off_v, gain_v};
        else if (i_addr == metrology_pkg::ADDR_INST)
          o_rdata <= {vcode, icode};
        else if (i_addr == metrology_pkg::ADDR_PINST)
          o_rdata <= pinst;
        else if (i_addr == metrology_pkg::ADDR_RMS)
          o_rdata <= {vrms, irms};
        else if (i_addr == metrology_pkg::ADDR_APPARENT)
          o_rdata <= apparent;
        else if (i_addr == metrology_pkg::ADDR_ACTIVE)
          o_rdata <= active;
        else if (i_addr == metrology_pkg::ADDR_REACTIVE)
          o_rdata <= reactive;
        else if (i_addr == metrology_pkg::ADDR_PF)
          o_rdata <= {14'h0000, pospf, posangle, pf};
        else if (i_addr == metrology_pkg::ADDR_STATUS)
          o_rdata <= {6'h00, last_n, 14'h0000, (state != ST_IDLE), o_overcurrent};
      end
    end
  end

endmodule

// ---- testbench/power_metrology_engine_checker.sv ----
`timescale 1ns/1ps
module power_metrology_engine_checker #(
  parameter int unsigned MAIN_DIV = metrology_pkg::MAIN_DIV
) (
  input wire logic        i_clk,
  input wire logic        i_rstn,
  input wire logic        i_ce,
  input wire logic [15:0] i_adc_i,
  input wire logic [15:0] i_adc_v,
  input wire logic [11:0] i_adc_aux,
  input wire logic [7:0]  i_temp,
  input wire logic [7:0]  i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic        i_we,
  input wire logic        i_re,
  input wire logic [31:0] o_rdata,
  input wire logic        o_overcurrent,
  input wire logic        o_result_ready
);
  // Saturates so a long idle stretch never wraps into a false short gap
  logic [15:0] gap;
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn || o_result_ready)
      gap <= 16'h0000;
    else if (gap != 16'hFFFF)
      gap <= gap + 16'h0001;
  end
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);
  AST_READY_PULSE: assert property (o_result_ready |=> !o_result_ready)
    else $error("result ready longer than one cycle");
  AST_READY_GAP: assert property (o_result_ready |-> gap >= 2 * MAIN_DIV)
    else $error("windows closer than the minimum count");
  AST_OC_HOLD: assert property ($changed(o_overcurrent) |=> $stable(o_overcurrent) [*8])
    else $error("overcurrent changed between aux updates");
  AST_OC_STATUS: assert property (i_re && i_addr == metrology_pkg::ADDR_STATUS
    |=> o_rdata[0] == $past(o_overcurrent))
    else $error("status overcurrent bit differs from pin");
  AST_PF_RANGE: assert property (i_re && i_addr == metrology_pkg::ADDR_PF
    |=> o_rdata[15:0] <= 16'h8000)
    else $error("power factor above one");
  AST_PF_SPARE: assert property (i_re && i_addr == metrology_pkg::ADDR_PF
    |=> o_rdata[31:18] == 14'h0000)
    else $error("power factor word has stray bits");
  AST_RDATA_IDLE: assert property (i_ce && !i_re |=> o_rdata == 32'h0000_0000)
    else $error("read data outside a read cycle");
  AST_UNMAPPED: assert property (i_re && i_addr > 8'h2C |=> o_rdata == 32'h0000_0000)
    else $error("unmapped read not zero");
endmodule
bind power_metrology_engine power_metrology_engine_checker #(.MAIN_DIV(MAIN_DIV)) u_chk (
  .i_clk(i_clk), .i_rstn(i_rstn), .i_ce(i_ce), .i_adc_i(i_adc_i), .i_adc_v(i_adc_v),
  .i_adc_aux(i_adc_aux), .i_temp(i_temp), .i_addr(i_addr), .i_wdata(i_wdata), .i_we(i_we),
  .i_re(i_re), .o_rdata(o_rdata), .o_overcurrent(o_overcurrent),
  .o_result_ready(o_result_ready));

// ---- testbench/line_source.sv ----
`timescale 1ns/1ps
module line_source #(
  parameter int unsigned HALF = 2000
) (
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  input  wire logic [15:0] i_amp_i,
  input  wire logic [15:0] i_amp_v,
  output logic      [15:0] o_adc_i,
  output logic      [15:0] o_adc_v
);
  // Offset start keeps edges midway between sample ticks
  logic [15:0] cnt;
  logic        pos;
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn || cnt == 16'(HALF - 1))
      cnt <= !i_rstn ? 16'h0032 : 16'h0000;
    else
      cnt <= cnt + 16'h0001;
    pos <= i_rstn && (pos ^ (cnt == 16'(HALF - 1)));
  end
  assign o_adc_i = pos ? i_amp_i : -i_amp_i;
  assign o_adc_v = pos ? i_amp_v : -i_amp_v;
endmodule

// ---- testbench/power_metrology_engine_tb.sv ----
`timescale 1ns/1ps
module power_metrology_engine_tb;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        we = 1'b0;
  logic        re = 1'b0;
  logic        ce = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [11:0] aux = 12'h000;
  logic [15:0] amp_i = 16'h0000;
  logic [15:0] amp_v = 16'h0200;
  logic [15:0] adc_i;
  logic [15:0] adc_v;
  logic [31:0] rdata;
  logic        oc;
  logic        rdy;
  logic [31:0] d;
  int          errors = 0;
  int          n_tests = 0;
  always #2.5 clk = ~clk;
  line_source u_src (.i_clk(clk), .i_rstn(rstn), .i_amp_i(amp_i), .i_amp_v(amp_v),
    .o_adc_i(adc_i), .o_adc_v(adc_v));
  power_metrology_engine #(.MAIN_DIV(100)) u_dut (.i_clk(clk), .i_rstn(rstn), .i_ce(ce),
    .i_adc_i(adc_i), .i_adc_v(adc_v), .i_adc_aux(aux), .i_temp(8'h00), .i_addr(addr),
    .i_wdata(wdata), .i_we(we), .i_re(re), .o_rdata(rdata), .o_overcurrent(oc),
    .o_result_ready(rdy));
  // ----------------------------------------------------------------
  // Bus and check helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    if (got !== exp)
      errors++;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    addr <= a;
    wdata <= v;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1;
    d = rdata;
    chk(d, e);
    @(posedge clk);
  endtask
  task automatic wait_rdy(input int n);
    for (int w = 0; w < n; w++)
    begin
      // Let the pulse just counted drop first
      @(negedge clk);
      for (int k = 0; k < 20000 && rdy !== 1'b1; k++)
        @(negedge clk);
      chk({31'h0, rdy}, 32'h1);
      @(posedge clk);
    end
  endtask
  task automatic oc_after(input logic [11:0] v, input logic e);
    aux <= v;
    repeat (450) @(posedge clk);
    #1;
    chk({31'h0, oc}, {31'h0, e});
    @(posedge clk);
  endtask
  task automatic give_verdict;
    $display("comparisons %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    rd(metrology_pkg::ADDR_CTRL, 32'h0200_0000);
    rd(metrology_pkg::ADDR_OC_THR, 32'h0000_07FF);
    rd(metrology_pkg::ADDR_TRIM_I, 32'h0000_4000);
    rd(metrology_pkg::ADDR_TRIM_V, 32'h0000_4000);
    rd(8'hFC, 32'h0000_0000);
  endtask
  task automatic t_fix;
    wr(metrology_pkg::ADDR_CTRL, 32'h0002_0001);
    wait_rdy(2);
    rd(metrology_pkg::ADDR_STATUS, 32'h0004_0000);
    rd(metrology_pkg::ADDR_APPARENT, 32'h0000_0000);
    rd(metrology_pkg::ADDR_PF, 32'h0002_0000);
    wr(metrology_pkg::ADDR_CTRL, 32'h0200_0000);
    amp_i <= 16'h0100;
  endtask
  task automatic t_dyn;
    wait_rdy(3);
    rd(metrology_pkg::ADDR_RMS, 32'h0200_0100);
    rd(metrology_pkg::ADDR_APPARENT, 32'h0002_0000);
    rd(metrology_pkg::ADDR_ACTIVE, 32'h0002_0000);
    rd(metrology_pkg::ADDR_REACTIVE, 32'h0000_0000);
    rd(metrology_pkg::ADDR_PF, 32'h0002_8000);
    rd(metrology_pkg::ADDR_STATUS, 32'h0028_0000);
    rd(metrology_pkg::ADDR_PINST, 32'h0002_0000);
    rd(metrology_pkg::ADDR_INST, 32'h0200_0100);
    chk({31'h0, d === 32'h0200_0100 || d === 32'hFE00_FF00}, 32'h1);
  endtask
  task automatic t_oc;
    wr(metrology_pkg::ADDR_OC_THR, 32'h0000_0100);
    oc_after(12'h101, 1'b1);
    oc_after(12'h100, 1'b0);
    wr(metrology_pkg::ADDR_TRIM_I, 32'h0000_8000);
    oc_after(12'h0C0, 1'b1);
    oc_after(12'hEFF, 1'b1);
  endtask
  task automatic t_ce;
    ce <= 1'b0;
    wr(metrology_pkg::ADDR_OC_THR, 32'h0000_0000);
    ce <= 1'b1;
    rd(metrology_pkg::ADDR_OC_THR, 32'h0000_0100);
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_regs();
    t_fix();
    t_dyn();
    t_oc();
    t_ce();
    give_verdict();
  end
  initial
  begin
    repeat (60000) @(posedge clk);
    errors++;
    give_verdict();
  end
endmodule
